// ===== hw/cag_top.sv
`default_nettype none
module cag_top
   import cag_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = cag_pkg::TICK_CYC
) (
   input  wire logic                      clk,          // 25 MHz core clock
   input  wire logic                      rst,          // Async reset, high
   input  wire logic [cag_pkg::ADDR_W-1:0] addr,        // Register address
   input  wire logic [cag_pkg::DATA_W-1:0] wdata,       // Write data
   input  wire logic                      wr,           // Write strobe
   input  wire logic                      rd,           // Read strobe
   output logic      [cag_pkg::DATA_W-1:0] rdata,       // Read data, next cycle
   input  wire logic                      sig_below,    // Level under threshold
   input  wire logic                      sig_above,    // Level over target band
   input  wire logic [cag_pkg::DRV_N-1:0] drv_down,     // Driver powered down
   input  wire logic                      short_det,    // Short circuit seen
   output logic      [6:0]                cell_pga_gain, // PGA gain code
   output logic                           agc_active,   // AGC owns PGA gain
   output logic                           silence,      // Silence mode
   output logic      [2:0]                noise_level,  // Threshold code to analog
   output logic      [1:0]                hys_sel,      // Hysteresis code
   output logic                           clip_step,    // Clip stepping enable
   output logic      [2:0]                target_sel,   // Target level code
   output logic                           flags_valid,  // Driver flags meaningful
   output logic                           irq           // Interrupt, level
);
   import cag_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic [15:0] agc_q;
   logic [6:0]  maxg_q;
   logic [2:0]  deb_q;
   logic [EV_N-1:0] ist_q, imask_q;
   logic        nf_q;
   logic [5:0]  drv_q;
   logic        short_q;
   cag_state_t  st_q;
   logic [1:0]  s_below, s_above, s_short;
   logic [11:0] s_drv;

   // Pins pass two flops before use
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_below <= 2'h0;
         s_above <= 2'h0;
         s_short <= 2'h0;
         s_drv   <= 12'hFFF;
      end else begin
         s_below <= {s_below[0], sig_below};
         s_above <= {s_above[0], sig_above};
         s_short <= {s_short[0], short_det};
         s_drv   <= {s_drv[5:0], drv_down};
      end
   end

   // Step periods in 0.5 ms ticks
   function automatic logic [9:0] step_ticks(input logic [3:0] tc, input logic up);
      logic [9:0] r;
      r = 10'h000;
      if (!up) begin
         case (tc[1:0])
            2'h0:    r = 10'h010;
            2'h1:    r = 10'h016;
            2'h2:    r = 10'h020;
            default: r = 10'h028;
         endcase
      end else begin
         case (tc[3:2])
            2'h0:    r = (tc[1:0] == 2'h0) ? 10'h014 : 10'h0C8;
            2'h1:    r = 10'h190;
            2'h2:    r = 10'h320;
            default: r = 10'h3E8;
         endcase
      end
      step_ticks = r;
   endfunction : step_ticks

   function automatic logic [6:0] deb_ticks(input logic [2:0] c);
      deb_ticks = (c == 3'h0) ? 7'h00 : 7'(7'h01 << (c - 3'h1));
   endfunction : deb_ticks

   ////////////////////////////////////////////////////////////////////////
   // Register writes
   logic wr_agc, wr_maxg, wr_ist, wr_imask;
   assign wr_agc   = wr && (addr == OFF_AGC_CTRL);
   assign wr_maxg  = wr && (addr == OFF_MAXG_DEB);
   assign wr_ist   = wr && (addr == OFF_INT_STAT);
   assign wr_imask = wr && (addr == OFF_INT_MASK);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         agc_q <= AGC_RESET;
      end else if (wr_agc) begin
         agc_q <= wdata & AGC_RW_MASK & ~(16'h1 << NF_BIT);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         maxg_q <= MAXG_RESET;
         deb_q  <= 3'h0;
      end else if (wr_maxg) begin
         maxg_q <= wdata[MAXG_LSB +: 7];
         deb_q  <= wdata[DEB_LSB +: 3];
      end
   end

   logic en;
   logic [3:0] tc;
   assign en = agc_q[EN_BIT];
   assign tc = agc_q[TC_LSB +: 4];

   ////////////////////////////////////////////////////////////////////////
   // fixed time base
   logic [15:0] tick_cnt_q;
   logic        tick;
   assign tick = (tick_cnt_q == 16'(TICK_CYCLES - 1));
   always_ff @(posedge clk or posedge rst) begin
      if (rst) tick_cnt_q <= 16'h0;
      else     tick_cnt_q <= tick ? 16'h0 : tick_cnt_q + 16'h1;
   end

   logic [6:0] deb_cnt_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q      <= CAG_ST_OFF;
         deb_cnt_q <= 7'h0;
      end else begin
         case (st_q)
            CAG_ST_OFF: begin
               deb_cnt_q <= 7'h0;
               if (en) st_q <= CAG_ST_NORMAL;
            end
            CAG_ST_NORMAL: begin
               if (!en) st_q <= CAG_ST_OFF;
               else if (!s_below[1]) deb_cnt_q <= 7'h0;
               else if (deb_cnt_q >= deb_ticks(deb_q)) st_q <= CAG_ST_SILENCE;
               else if (tick) deb_cnt_q <= deb_cnt_q + 7'h1;
            end
            CAG_ST_SILENCE: begin
               deb_cnt_q <= 7'h0;
               if (!en) st_q <= CAG_ST_OFF;
               else if (!s_below[1]) st_q <= CAG_ST_NORMAL;
            end
            default: st_q <= CAG_ST_OFF;
         endcase
      end
   end

   logic [9:0] step_cnt_q;
   logic       want_up, step_due;
   assign want_up  = !s_above[1] && !s_below[1];
   assign step_due = tick && (step_cnt_q >= step_ticks(tc, want_up) - 10'h1);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) step_cnt_q <= 10'h0;
      else if (st_q != CAG_ST_NORMAL || step_due) step_cnt_q <= 10'h0;
      else if (tick) step_cnt_q <= step_cnt_q + 10'h1;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) cell_pga_gain <= 7'h0;
      else if (!en) cell_pga_gain <= 7'h0;
      else if (cell_pga_gain > maxg_q) cell_pga_gain <= maxg_q;
      else if (step_due && s_above[1] && cell_pga_gain != 7'h0)
         cell_pga_gain <= cell_pga_gain - 7'h1;
      else if (step_due && want_up && cell_pga_gain < maxg_q && cell_pga_gain < MAX_GAIN_CODE)
         cell_pga_gain <= cell_pga_gain + 7'h1;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         nf_q        <= 1'b0;
         drv_q       <= DRV_RESET;
         short_q     <= 1'b0;
         agc_active  <= 1'b0;
         silence     <= 1'b0;
         flags_valid <= 1'b1;
      end else begin
         nf_q        <= en & s_below[1];
         drv_q       <= s_drv[11:6];
         short_q     <= s_short[1];
         agc_active  <= en;
         silence     <= (st_q == CAG_ST_SILENCE);
         flags_valid <= !s_short[1];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         noise_level <= 3'h0;
         hys_sel     <= 2'h0;
         clip_step   <= 1'b0;
         target_sel  <= 3'h0;
      end else begin
         noise_level <= agc_q[NL_LSB +: 3];
         hys_sel     <= agc_q[HYS_LSB +: 2];
         clip_step   <= agc_q[CLP_BIT];
         target_sel  <= agc_q[TG_LSB +: 3];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupts: set wins over clear
   logic [EV_N-1:0] ev;
   logic nf_prev_q, sil_prev_q, sh_prev_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         nf_prev_q  <= 1'b0;
         sil_prev_q <= 1'b0;
         sh_prev_q  <= 1'b0;
      end else begin
         nf_prev_q  <= nf_q;
         sil_prev_q <= silence;
         sh_prev_q  <= short_q;
      end
   end
   assign ev = {short_q & ~sh_prev_q, silence & ~sil_prev_q, nf_q & ~nf_prev_q};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ist_q   <= '0;
         imask_q <= '0;
         irq     <= 1'b0;
      end else begin
         ist_q <= (ist_q & ~(wr_ist ? wdata[EV_N-1:0] : '0)) | ev;
         if (wr_imask) imask_q <= wdata[EV_N-1:0];
         irq <= |(ist_q & imask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read port
   always_ff @(posedge clk or posedge rst) begin
      if (rst) rdata <= '0;
      else if (rd) begin
         case (addr)
            OFF_AGC_CTRL:  rdata <= (agc_q & AGC_RW_MASK) | (16'(nf_q) << NF_BIT);
            OFF_DRV_STAT:  rdata <= 16'(drv_q) << DRV_LSB;
            OFF_MAXG_DEB:  rdata <= (16'(maxg_q) << MAXG_LSB) | (16'(deb_q) << DEB_LSB);
            OFF_INT_STAT:  rdata <= 16'(ist_q);
            OFF_INT_MASK:  rdata <= 16'(imask_q);
            OFF_GAIN_STAT: rdata <= {7'h0, short_q, 1'b0, cell_pga_gain};
            default:       rdata <= '0;
         endcase
      end else rdata <= '0;
   end

   ////////////////////////////////////////////////////////////////////////
   // gain ceiling
   a_gain_ceiling: assert property (@(posedge clk) disable iff (rst)
      $past(cell_pga_gain) <= $past(maxg_q) |-> cell_pga_gain <= maxg_q || wr_maxg || $past(wr_maxg))
      else $error("gain above maximum");
   // reserved bit
   // The control, interrupt and gain status words have D15 reserved; the driver and max gain words use it
   a_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
      $past(rd && addr == OFF_AGC_CTRL) |-> rdata[15] == 1'b0) else $error("reserved bit set");
   a_noise_flag: assert property (@(posedge clk) disable iff (rst)
      !en |=> !nf_q) else $error("noise flag while disabled");
   a_gain_off: assert property (@(posedge clk) disable iff (rst)
      !en |=> cell_pga_gain == 7'h0) else $error("gain moved while off");
   a_flags_valid: assert property (@(posedge clk) disable iff (rst)
      s_short[1] |=> !flags_valid) else $error("flags valid during short");
   a_ro_write: assert property (@(posedge clk) disable iff (rst)
      wr_agc |=> agc_q[15:14] == 2'h0) else $error("read-only bits written");
   a_drv_track: assert property (@(posedge clk) disable iff (rst)
      ##1 drv_q == $past(s_drv[11:6])) else $error("driver flags stale");
   a_deb_zero: assert property (@(posedge clk) disable iff (rst)
      st_q == CAG_ST_NORMAL && en && s_below[1] && deb_q == 3'h0 |=> st_q == CAG_ST_SILENCE)
      else $error("silence entry late");
   a_clip_step: assert property (@(posedge clk) disable iff (rst)
      wr_agc |=> ##1 clip_step == $past(wdata[CLP_BIT], 2)) else $error("clip step not applied");
   a_field_copy: assert property (@(posedge clk) disable iff (rst)
      ##1 {noise_level, hys_sel, target_sel} == $past({agc_q[NL_LSB +: 3], agc_q[HYS_LSB +: 2], agc_q[TG_LSB +: 3]}))
      else $error("field copy stale");
endmodule : cag_top
`default_nettype wire

// ===== include/cag_pkg.sv
`default_nettype none
package cag_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 16;
   // Register offsets
   localparam logic [7:0] OFF_AGC_CTRL   = 8'h24;
   localparam logic [7:0] OFF_DRV_STAT   = 8'h25;
   localparam logic [7:0] OFF_MAXG_DEB   = 8'h27;
   localparam logic [7:0] OFF_INT_STAT   = 8'h28;
   localparam logic [7:0] OFF_INT_MASK   = 8'h29;
   localparam logic [7:0] OFF_GAIN_STAT  = 8'h2A;
   // Control register fields
   localparam int unsigned NF_BIT   = 14;
   localparam int unsigned NL_LSB   = 11;
   localparam int unsigned HYS_LSB  = 9;
   localparam int unsigned CLP_BIT  = 8;
   localparam int unsigned TG_LSB   = 5;
   localparam int unsigned TC_LSB   = 1;
   localparam int unsigned EN_BIT   = 0;
   localparam logic [15:0] AGC_RW_MASK = 16'h3FFF;
   localparam logic [15:0] AGC_RESET   = 16'h0000;
   // Max gain / debounce register fields
   localparam int unsigned MAXG_LSB = 9;
   localparam int unsigned DEB_LSB  = 6;
   localparam logic [6:0] MAXG_RESET = 7'h7F;
   // Driver status fields
   localparam int unsigned DRV_LSB = 10;
   localparam int unsigned DRV_N   = 6;
   localparam logic [5:0] DRV_RESET = 6'h3F;
   // Interrupt event bits
   localparam int unsigned EV_NOISE  = 0;
   localparam int unsigned EV_QUIET  = 1;
   localparam int unsigned EV_SHORT  = 2;
   localparam int unsigned EV_N      = 3;
   // Time base: 25 MHz clock, 0.5 ms tick
   localparam int unsigned CLK_HZ    = 25_000_000;
   localparam int unsigned TICK_US   = 500;
   localparam int unsigned TICK_CYC  = CLK_HZ / 1_000_000 * TICK_US;
   localparam logic [6:0] MAX_GAIN_CODE = 7'h5E;
   typedef enum logic [1:0] {CAG_ST_OFF, CAG_ST_NORMAL, CAG_ST_SILENCE} cag_state_t;
endpackage : cag_pkg
`default_nettype wire

// ===== dv/cag_top_test.sv
`default_nettype none
module cag_top_test
   import cag_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned TICKS = 4;
   logic                clk;
   logic                rst;
   logic [ADDR_W-1:0]   addr;
   logic [DATA_W-1:0]   wdata;
   logic                wr;
   logic                rd;
   logic [DATA_W-1:0]   rdata;
   logic                sig_below;
   logic                sig_above;
   logic [DRV_N-1:0]    drv_down;
   logic                short_det;
   logic [6:0]          cell_pga_gain;
   logic                agc_active;
   logic                silence;
   logic [2:0]          noise_level;
   logic [1:0]          hys_sel;
   logic                clip_step;
   logic [2:0]          target_sel;
   logic                flags_valid;
   logic                irq;
   logic                irq_a;
   logic [15:0]         w;
   int                  errors;
   int                  tests_run;
   cag_top #(.TICK_CYCLES(TICKS)) u_cag_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .sig_below(sig_below), .sig_above(sig_above), .drv_down(drv_down),
      .short_det(short_det), .cell_pga_gain(cell_pga_gain), .agc_active(agc_active), .silence(silence),
      .noise_level(noise_level), .hys_sel(hys_sel), .clip_step(clip_step), .target_sel(target_sel),
      .flags_valid(flags_valid), .irq(irq));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_cyc
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   // Data stands only in the cycle after the strobe
   task automatic chk_reg(input string name, input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] d;
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
      tests_run++;
      if (d !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", name, exp, d);
      end
   endtask : chk_reg
   task automatic chk_sig(input string name, input logic [6:0] got, input logic [6:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_sig
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      $display("FAIL watchdog expired");
      end_sim();
   end
   initial begin
      {rst, addr, wdata, wr, rd, sig_below, sig_above, short_det} = '0;
      rst      = 1'b1;
      drv_down = 6'h3F;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      chk_reg("ctrl reset", OFF_AGC_CTRL, 16'h0000);
      chk_reg("drv reset", OFF_DRV_STAT, 16'hFC00);
      chk_reg("maxg reset", OFF_MAXG_DEB, 16'hFE00);
      chk_reg("unmapped", 8'h30, 16'h0000);
      chk_sig("valid reset", {6'h00, flags_valid}, 7'h01);
      $display("reset test done");
      // Every noise and target code once; flag bit written high must drop, reserved bit kept 0
      for (int i = 0; i < 8; i++) begin
         w = {2'b00, 3'(i), 2'(i), 1'(i), 3'(7 - i), 4'(i + 8), 1'b0};
         wr_reg(OFF_AGC_CTRL, w | 16'h4000);
         chk_reg("ctrl rw", OFF_AGC_CTRL, w);
         chk_sig("noise_level", {4'h0, noise_level}, 7'(i));
         chk_sig("hys_sel", {5'h00, hys_sel}, 7'(i % 4));
         chk_sig("clip_step", {6'h00, clip_step}, 7'(i % 2));
         chk_sig("target_sel", {4'h0, target_sel}, 7'(7 - i));
         chk_sig("agc off", {6'h00, agc_active}, 7'h00);
      end
      $display("field test done");
      drv_down <= 6'h2A;
      wr_reg(OFF_DRV_STAT, 16'h0000);
      wait_cyc(5);
      chk_reg("drv flags", OFF_DRV_STAT, 16'hA800);
      short_det <= 1'b1;
      wait_cyc(5);
      chk_sig("valid short", {6'h00, flags_valid}, 7'h00);
      chk_reg("int short", OFF_INT_STAT, 16'h0004);
      wr_reg(OFF_INT_MASK, 16'h0000);
      wait_cyc(3);
      irq_a = irq;
      wr_reg(OFF_INT_MASK, 16'h0007);
      wait_cyc(3);
      chk_sig("irq mask", {6'h00, irq_a ^ irq}, 7'h01);
      short_det <= 1'b0;
      wait_cyc(5);
      wr_reg(OFF_INT_STAT, 16'h0004);
      chk_reg("int clear", OFF_INT_STAT, 16'h0000);
      chk_sig("irq clear", {6'h00, irq}, 7'h00);
      chk_sig("valid back", {6'h00, flags_valid}, 7'h01);
      $display("driver test done");
      wr_reg(OFF_MAXG_DEB, 16'h0A00);
      chk_reg("maxg rw", OFF_MAXG_DEB, 16'h0A00);
      wr_reg(OFF_AGC_CTRL, 16'h0001);
      // Code 0000 decays one step per 20 ticks
      wait_cyc(200);
      chk_sig("decay 10ms", cell_pga_gain, 7'h02);
      wait_cyc(1000);
      chk_sig("agc on", {6'h00, agc_active}, 7'h01);
      chk_sig("gain clamp", cell_pga_gain, 7'h05);
      chk_reg("gain stat", OFF_GAIN_STAT, 16'h0005);
      sig_above <= 1'b1;
      wait_cyc(600);
      chk_sig("gain down", cell_pga_gain, 7'h00);
      sig_above <= 1'b0;
      sig_below <= 1'b1;
      wait_cyc(20);
      chk_reg("noise flag", OFF_AGC_CTRL, 16'h4001);
      chk_sig("silence", {6'h00, silence}, 7'h01);
      chk_reg("int noise", OFF_INT_STAT, 16'h0003);
      wr_reg(OFF_AGC_CTRL, 16'h0000);
      wr_reg(OFF_INT_STAT, 16'h0003);
      wait_cyc(3);
      chk_sig("agc off", {6'h00, agc_active}, 7'h00);
      chk_sig("gain off", cell_pga_gain, 7'h00);
      chk_reg("int done", OFF_INT_STAT, 16'h0000);
      $display("agc test done");
      // Code 0001 decays one step per 200 ticks; debounce 32 ms is 64 ticks
      sig_below <= 1'b0;
      wr_reg(OFF_MAXG_DEB, 16'h0BC0);
      wr_reg(OFF_AGC_CTRL, 16'h0003);
      wait_cyc(400);
      chk_sig("decay early", cell_pga_gain, 7'h00);
      wait_cyc(600);
      chk_sig("decay 100ms", cell_pga_gain, 7'h01);
      sig_below <= 1'b1;
      wait_cyc(120);
      chk_sig("debounce early", {6'h00, silence}, 7'h00);
      wait_cyc(280);
      chk_sig("debounce done", {6'h00, silence}, 7'h01);
      chk_reg("int debounce", OFF_INT_STAT, 16'h0003);
      $display("timing test done");
      end_sim();
   end
endmodule : cag_top_test
`default_nettype wire
